// ### nfps_feature_store.sv
// Feature-parameter store of a flash target, reached by feature
// set/get commands, with reset-command retention per feature.
// Assumes the command decoder hands over one-cycle pulses on sys_clk;
// rst is the power-on reset. Only chain_enable_in comes from a pin.
`timescale 1ns/1ps
`default_nettype none
module nfps_feature_store #(
  parameter int LUNS = 4,
  parameter bit SUPPORT_FEATURES = 1'b1,
  parameter logic [5:0] FEATURE_MASK = 6'h3f
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Feature commands
  input wire logic set_req,
  input wire logic get_req,
  input wire logic [7:0] feat_addr,
  input wire nfps_pkg::nfps_params_type set_params,
  output logic get_valid,
  output nfps_pkg::nfps_params_type get_params,
  // Reset commands
  input wire logic reset_req,
  input wire logic [7:0] reset_code,
  // Program and volume select commands
  input wire logic prog_req,
  input wire logic [2:0] prog_lun,
  input wire logic vol_sel_req,
  input wire logic [3:0] vol_sel_addr,
  // Per-volume termination already configured
  input wire logic term_matrix_set,
  // Volume chain pins
  input wire logic chain_enable_in,
  output logic chain_enable_out,
  output logic target_enabled,
  // Timing feature
  output logic [3:0] timing_mode,
  output nfps_pkg::nfps_iface_type iface_type,
  output logic program_clear_select,
  // Effective double-rate settings
  output logic ext_reference_enable,
  output logic complementary_strobe_enable,
  output logic complementary_read_strobe_enable,
  output logic [3:0] on_die_termination,
  output logic [2:0] warm_out_cycles,
  output logic [2:0] warm_in_cycles,
  // Other features
  output logic [1:0] drive_level,
  output logic prog_supply_enable,
  output logic retry_disable,
  output logic [3:0] volume_addr,
  output logic volume_selected,
  output logic [LUNS-1:0] page_clear_mask
);

  // ----------------------------------------------------------------------
  // Elaboration checks and decoders
  // ----------------------------------------------------------------------
  if (LUNS < 1 || LUNS > 8) begin : g_bad_luns
    $error("LUNS must lie between 1 and 8");
  end

  // One-hot feature select, bit order timing..volume
  function automatic logic [5:0] feat_sel(input logic [7:0] a);
    logic [5:0] s;
    s = 6'h00;
    unique case (a)
      nfps_pkg::FA_TIMING: s = 6'h01;
      nfps_pkg::FA_DDR_CFG: s = 6'h02;
      nfps_pkg::FA_DRIVE: s = 6'h04;
      nfps_pkg::FA_SUPPLY: s = 6'h08;
      nfps_pkg::FA_ECC: s = 6'h10;
      nfps_pkg::FA_VOLUME: s = 6'h20;
      default: s = 6'h00; // Reserved and vendor space
    endcase
    return SUPPORT_FEATURES ? (s & FEATURE_MASK) : 6'h00;
  endfunction : feat_sel

  // Warm-up code to cycle count, reserved codes give none
  function automatic logic [2:0] warm_cycles(input logic [3:0] c);
    logic [2:0] n;
    n = 3'h0;
    unique case (c)
      4'h1: n = 3'h1;
      4'h2: n = 3'h2;
      4'h3: n = 3'h4;
      default: n = 3'h0;
    endcase
    return n;
  endfunction : warm_cycles

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  logic [5:0] set_sel;
  logic [5:0] get_sel;
  logic full_rst;
  logic any_rst;
  logic set_ok;

  // A reset command in the same cycle beats a feature write
  always_comb begin
    set_sel = feat_sel(feat_addr);
    get_sel = feat_sel(feat_addr);
    full_rst = reset_req && reset_code == nfps_pkg::RST_FULL;
    any_rst = reset_req && (reset_code == nfps_pkg::RST_FULL ||
              reset_code == nfps_pkg::RST_SYNC ||
              reset_code == nfps_pkg::RST_LUN);
    set_ok = set_req && !any_rst;
  end

  // ----------------------------------------------------------------------
  // Stored features
  // ----------------------------------------------------------------------
  nfps_pkg::nfps_timing_type tim_q, tim_d;
  nfps_pkg::nfps_ddr_cfg_type ddr_q, ddr_d;
  logic [1:0] drive_q, drive_d;
  logic supply_q, supply_d;
  logic ecc_q, ecc_d;
  logic [3:0] vol_q, vol_d;
  logic appointed_q, appointed_d;
  logic vsel_q, vsel_d;

  // Next feature values; only defined fields are taken in
  always_comb begin
    tim_d = tim_q;
    ddr_d = ddr_q;
    drive_d = drive_q;
    supply_d = supply_q;
    ecc_d = ecc_q;
    vol_d = vol_q;
    appointed_d = appointed_q;
    vsel_d = vsel_q;
    if (full_rst) begin
      tim_d.iface = nfps_pkg::IF_SDR;
      ddr_d = '0;
    end
    if (set_ok && set_sel[0]) begin
      tim_d.mode = set_params.p1[nfps_pkg::TM_LSB +: 4];
      tim_d.iface = nfps_pkg::nfps_iface_type'(
        set_params.p1[nfps_pkg::IF_LSB +: 2]);
      tim_d.clr_sel = set_params.p1[nfps_pkg::CLR_SEL_BIT];
    end
    if (set_ok && set_sel[1]) begin
      ddr_d.ref_en = set_params.p1[nfps_pkg::REF_EN_BIT];
      ddr_d.stb_c = set_params.p1[nfps_pkg::STB_C_BIT];
      ddr_d.rd_c = set_params.p1[nfps_pkg::RD_C_BIT];
      ddr_d.term = set_params.p1[nfps_pkg::TERM_LSB +: 4];
      ddr_d.warm_out = set_params.p2[nfps_pkg::WOUT_LSB +: 4];
      ddr_d.warm_in = set_params.p2[nfps_pkg::WIN_LSB +: 4];
    end
    if (set_ok && set_sel[2]) begin
      drive_d = set_params.p1[1:0];
    end
    if (set_ok && set_sel[3]) begin
      supply_d = set_params.p1[nfps_pkg::ONE_BIT];
    end
    if (set_ok && set_sel[4]) begin
      ecc_d = set_params.p1[nfps_pkg::ONE_BIT];
    end
    // A second appointment is dropped: one per power cycle
    if (set_ok && set_sel[5] && !appointed_q) begin
      vol_d = set_params.p1[3:0];
      appointed_d = 1'b1;
      vsel_d = 1'b0;
    end else if (vol_sel_req && appointed_q) begin
      vsel_d = vol_sel_addr == vol_q;
    end
  end

  // Power-on values; only a full reset command touches these, forcing IF_SDR and clearing ddr_q
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tim_q <= '{clr_sel: 1'b0, iface: nfps_pkg::IF_SDR,
                 mode: nfps_pkg::TM_RST};
      ddr_q <= '0;
      drive_q <= nfps_pkg::DRIVE_RST;
      supply_q <= 1'b0;
      ecc_q <= 1'b0;
      vol_q <= 4'h0;
      appointed_q <= 1'b0;
      vsel_q <= 1'b0;
    end else begin
      tim_q <= tim_d;
      ddr_q <= ddr_d;
      drive_q <= drive_d;
      supply_q <= supply_d;
      ecc_q <= ecc_d;
      vol_q <= vol_d;
      appointed_q <= appointed_d;
      vsel_q <= vsel_d;
    end
  end

  // ----------------------------------------------------------------------
  // Feature read
  // ----------------------------------------------------------------------
  nfps_pkg::nfps_params_type get_q, get_d;
  logic get_valid_q, get_valid_d;

  // Reserved bits and unknown addresses read as zero
  always_comb begin
    get_d = '0;
    get_valid_d = get_req;
    if (get_req) begin
      unique case (1'b1)
        get_sel[0]: get_d.p1 = {1'b0, tim_q.clr_sel, tim_q.iface, tim_q.mode};
        get_sel[1]: begin
          get_d.p1 = {ddr_q.term, 1'b0, ddr_q.rd_c, ddr_q.stb_c,
                      ddr_q.ref_en};
          get_d.p2 = {ddr_q.warm_out, ddr_q.warm_in};
        end
        get_sel[2]: get_d.p1 = {6'h00, drive_q};
        get_sel[3]: get_d.p1 = {7'h00, supply_q};
        get_sel[4]: get_d.p1 = {7'h00, ecc_q};
        get_sel[5]: get_d.p1 = {4'h0, appointed_q ? vol_q : 4'h0};
        default: get_d = '0;
      endcase
    end
  end

  // Answer one cycle after the request
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      get_q <= '0;
      get_valid_q <= 1'b0;
    end else begin
      get_q <= get_d;
      get_valid_q <= get_valid_d;
    end
  end

  // ----------------------------------------------------------------------
  // Effective double-rate settings
  // ----------------------------------------------------------------------
  nfps_pkg::nfps_ddr_cfg_type eff_q, eff_d;
  logic [2:0] wout_q, wout_d;
  logic [2:0] win_q, win_d;

  // Gated by the next interface so a change lands at once
  always_comb begin
    eff_d = '0;
    if (tim_d.iface == nfps_pkg::IF_DDR2) begin
      eff_d = ddr_d;
    end
    // Reserved or overridden termination falls back to off
    if (term_matrix_set || eff_d.term > nfps_pkg::TERM_MAX) begin
      eff_d.term = nfps_pkg::NIB_ZERO;
    end
    wout_d = warm_cycles(eff_d.warm_out);
    win_d = warm_cycles(eff_d.warm_in);
  end

  // Register the effective settings
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      eff_q <= '0;
      wout_q <= 3'h0;
      win_q <= 3'h0;
    end else begin
      eff_q <= eff_d;
      wout_q <= wout_d;
      win_q <= win_d;
    end
  end

  // ----------------------------------------------------------------------
  // Volume chain and page clear
  // ----------------------------------------------------------------------
  logic chain_in_s;
  logic chain_out_q, chain_out_d;
  logic tgt_en_q, tgt_en_d;

  nfps_sync2 #(
    .W(1)
  ) u_chain_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(chain_enable_in),
    .sync_out(chain_in_s)
  );

  // Once appointed the chain input no longer matters
  always_comb begin
    chain_out_d = appointed_d;
    tgt_en_d = appointed_d ? 1'b1 : chain_in_s;
  end

  // Register chain outputs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chain_out_q <= 1'b0;
      tgt_en_q <= 1'b0;
    end else begin
      chain_out_q <= chain_out_d;
      tgt_en_q <= tgt_en_d;
    end
  end

  nfps_page_clear #(
    .LUNS(LUNS)
  ) u_page_clear (
    .sys_clk(sys_clk),
    .rst(rst),
    .prog_req(prog_req),
    .prog_lun(prog_lun),
    .clear_select(tim_q.clr_sel),
    .clear_mask(page_clear_mask)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Every output is a flop output
  assign get_valid = get_valid_q;
  assign get_params = get_q;
  assign chain_enable_out = chain_out_q;
  assign target_enabled = tgt_en_q;
  assign timing_mode = tim_q.mode;
  assign iface_type = tim_q.iface;
  assign program_clear_select = tim_q.clr_sel;
  assign ext_reference_enable = eff_q.ref_en;
  assign complementary_strobe_enable = eff_q.stb_c;
  assign complementary_read_strobe_enable = eff_q.rd_c;
  assign on_die_termination = eff_q.term;
  assign warm_out_cycles = wout_q;
  assign warm_in_cycles = win_q;
  assign drive_level = drive_q;
  assign prog_supply_enable = supply_q;
  assign retry_disable = ecc_q;
  assign volume_addr = vol_q;
  assign volume_selected = vsel_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_full_rst_sdr: assert property (@(posedge sys_clk) disable iff (rst)
    reset_req && reset_code == nfps_pkg::RST_FULL |=>
    iface_type == nfps_pkg::IF_SDR && timing_mode == $past(timing_mode))
    else $error("full reset did not force single rate");
  a_ddr_cfg_clear: assert property (@(posedge sys_clk) disable iff (rst)
    reset_req && reset_code == nfps_pkg::RST_FULL |=> ddr_q == '0)
    else $error("full reset left double-rate config");
  a_ddr_cfg_kept: assert property (@(posedge sys_clk) disable iff (rst)
    reset_req && (reset_code == nfps_pkg::RST_SYNC ||
    reset_code == nfps_pkg::RST_LUN) |=> $stable(ddr_q))
    else $error("sync or LUN reset changed double-rate config");
  a_drive_kept: assert property (@(posedge sys_clk) disable iff (rst)
    reset_req |=> $stable(drive_level) && $stable(prog_supply_enable))
    else $error("reset command changed drive or supply");
  a_ddr_gate: assert property (@(posedge sys_clk) disable iff (rst)
    iface_type != nfps_pkg::IF_DDR2 |-> !ext_reference_enable &&
    !complementary_strobe_enable && warm_in_cycles == 3'h0)
    else $error("double-rate config active outside its interface");
  a_unknown_zero: assert property (@(posedge sys_clk) disable iff (rst)
    get_req && feat_sel(feat_addr) == 6'h00 |=>
    get_valid && get_params == '0)
    else $error("unknown feature read not zero");
  a_chain_high: assert property (@(posedge sys_clk) disable iff (rst)
    set_ok && set_sel[5] |=> chain_enable_out[*4])
    else $error("chain output not high after appointment");
  a_retry_set: assert property (@(posedge sys_clk) disable iff (rst)
    set_ok && set_sel[4] |=> retry_disable == $past(set_params.p1[0]))
    else $error("retry disable not taken from write");
  a_warm_map: assert property (@(posedge sys_clk) disable iff (rst)
    tim_d.iface == nfps_pkg::IF_DDR2 && ddr_d.warm_out == 4'h3 |=>
    warm_out_cycles == 3'h4)
    else $error("warm-up code 3 did not give four cycles");

endmodule : nfps_feature_store
`default_nettype wire

// ### nfps_pkg.sv
// Constants and types of the feature-parameter store.
// Assumes a single 200 MHz clock domain and no software bus.
package nfps_pkg;

  // ----------------------------------------------------------------------
  // Feature addresses and reset command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] FA_TIMING = 8'h01;
  localparam logic [7:0] FA_DDR_CFG = 8'h02;
  localparam logic [7:0] FA_DRIVE = 8'h10;
  localparam logic [7:0] FA_SUPPLY = 8'h30;
  localparam logic [7:0] FA_ECC = 8'h50;
  localparam logic [7:0] FA_VOLUME = 8'h58;
  localparam logic [7:0] FA_VENDOR_LO = 8'h80;
  localparam logic [7:0] RST_FULL = 8'hff;
  localparam logic [7:0] RST_SYNC = 8'hfc;
  localparam logic [7:0] RST_LUN = 8'hfa;

  // ----------------------------------------------------------------------
  // Field positions inside P1 and P2
  // ----------------------------------------------------------------------
  localparam int TM_LSB = 0;
  localparam int IF_LSB = 4;
  localparam int CLR_SEL_BIT = 6;
  localparam int REF_EN_BIT = 0;
  localparam int STB_C_BIT = 1;
  localparam int RD_C_BIT = 2;
  localparam int TERM_LSB = 4;
  localparam int WIN_LSB = 0;
  localparam int WOUT_LSB = 4;
  localparam int ONE_BIT = 0;

  // ----------------------------------------------------------------------
  // Power-on values and limits
  // ----------------------------------------------------------------------
  localparam logic [3:0] TM_RST = 4'h0;
  localparam logic [1:0] DRIVE_RST = 2'h2;
  localparam logic [3:0] TERM_MAX = 4'h5;
  localparam logic [3:0] NIB_ZERO = 4'h0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    IF_SDR = 2'b00,
    IF_DDR1 = 2'b01,
    IF_DDR2 = 2'b10,
    IF_RSVD = 2'b11
  } nfps_iface_type;

  typedef struct packed {
    logic [7:0] p4;
    logic [7:0] p3;
    logic [7:0] p2;
    logic [7:0] p1;
  } nfps_params_type;

  typedef struct packed {
    logic clr_sel;
    nfps_iface_type iface;
    logic [3:0] mode;
  } nfps_timing_type;

  typedef struct packed {
    logic [3:0] term;
    logic rd_c;
    logic stb_c;
    logic ref_en;
    logic [3:0] warm_out;
    logic [3:0] warm_in;
  } nfps_ddr_cfg_type;

endpackage : nfps_pkg

// ### nfps_sync2.sv
// Two-stage synchroniser for levels that arrive from pins.
// Assumes the level is slow against sys_clk.
`timescale 1ns/1ps
`default_nettype none
module nfps_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // First stage is read only by the second
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : nfps_sync2
`default_nettype wire

// ### nfps_page_clear.sv
// Page-register clear mask issued when a program command arrives.
// Assumes prog_req is a one-cycle pulse on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module nfps_page_clear #(
  parameter int LUNS = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Program command
  input wire logic prog_req,
  input wire logic [2:0] prog_lun,
  input wire logic clear_select,
  // Clear strobes, one per LUN
  output logic [LUNS-1:0] clear_mask
);
  logic [LUNS-1:0] mask_d;

  // Select bit low clears every LUN, high only the addressed one
  for (genvar i = 0; i < LUNS; i++) begin : g_lun
    always_comb begin
      mask_d[i] = prog_req && (!clear_select ||
                  prog_lun == 3'(i));
    end
  end

  // Register the strobes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clear_mask <= '0;
    end else begin
      clear_mask <= mask_d;
    end
  end

  a_clear_all: assert property (@(posedge sys_clk) disable iff (rst)
    prog_req && !clear_select |=> clear_mask == {LUNS{1'b1}})
    else $error("program clear did not reach all LUNs");
  a_clear_one: assert property (@(posedge sys_clk) disable iff (rst)
    prog_req && clear_select |=>
    clear_mask == (LUNS'(1) << $past(prog_lun)))
    else $error("addressed program clear hit the wrong LUN");
endmodule : nfps_page_clear
`default_nettype wire

// ### nfps_host_model.sv
// Host controller model that issues feature and reset commands.
// Assumes the store samples requests on the rising edge of sys_clk.
`timescale 1ns/1ps
`default_nettype none
module nfps_host_model (
  // Clock
  input wire logic sys_clk,
  // Commands
  output logic set_req,
  output logic get_req,
  output logic [7:0] feat_addr,
  output nfps_pkg::nfps_params_type set_params,
  output logic reset_req,
  output logic [7:0] reset_code,
  // Answer
  input wire logic get_valid,
  input wire nfps_pkg::nfps_params_type get_params
);
  // Idle levels at time zero
  initial begin
    set_req = 1'b0;
    get_req = 1'b0;
    reset_req = 1'b0;
    feat_addr = 8'h00;
    reset_code = 8'h00;
    set_params = 32'h00000000;
  end

  // Feature write; modes are only ones the part advertises
  // Bytes p3 and p4 go out as zero while set_req is high, then as ff
  task automatic fset(input logic [7:0] a, input logic [7:0] p1,
                      input logic [7:0] p2);
    @(negedge sys_clk);
    feat_addr = a;
    set_params = {16'h0000, p2, p1};
    set_req = 1'b1;
    @(negedge sys_clk);
    set_req = 1'b0;
    set_params = ~set_params; // Stale bytes never look valid
    @(negedge sys_clk);
  endtask : fset

  // Feature read; a missing answer leaves the result unknown
  task automatic fget(input logic [7:0] a, output logic [31:0] p);
    int n;
    p = {32{1'bx}};
    @(negedge sys_clk);
    feat_addr = a;
    get_req = 1'b1;
    @(negedge sys_clk);
    get_req = 1'b0;
    for (n = 0; n < 3; n++) begin
      if (get_valid === 1'b1) p = get_params;
      @(negedge sys_clk);
    end
  endtask : fget

  // Reset command; the full code leaves double rate, as a timing write can too
  task automatic frst(input logic [7:0] code);
    @(negedge sys_clk);
    reset_code = code;
    reset_req = 1'b1;
    @(negedge sys_clk);
    reset_req = 1'b0;
    @(negedge sys_clk);
  endtask : frst
endmodule : nfps_host_model
`default_nettype wire

// ### nfps_feature_store_tb.sv
// Self-checking bench for the feature-parameter store.
// Assumes the host model drives every feature and reset command.
`timescale 1ns/1ps
`default_nettype none
module nfps_feature_store_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic prog_req = 1'b0;
  logic [2:0] prog_lun = 3'h0;
  logic vol_sel_req = 1'b0;
  logic [3:0] vol_sel_addr = 4'h0;
  logic term_matrix_set = 1'b0;
  logic chain_enable_in = 1'b0;
  logic set_req, get_req, reset_req, get_valid;
  logic [7:0] feat_addr, reset_code;
  nfps_pkg::nfps_params_type set_params, get_params;
  logic chain_enable_out, target_enabled, program_clear_select;
  logic [3:0] timing_mode, on_die_termination, volume_addr;
  nfps_pkg::nfps_iface_type iface_type;
  logic ext_reference_enable, complementary_strobe_enable;
  logic complementary_read_strobe_enable;
  logic [2:0] warm_out_cycles, warm_in_cycles;
  logic [1:0] drive_level;
  logic prog_supply_enable, retry_disable, volume_selected;
  logic [3:0] page_clear_mask;
  int fails = 0;
  int n_compared = 0;
  logic [31:0] rd;

  // ---------------------------------------------------------------
  // Clock, design and host
  // ---------------------------------------------------------------
  always #2.5 sys_clk = ~sys_clk;

  nfps_feature_store #(.LUNS(4)) u_dut (.sys_clk, .rst, .set_req,
    .get_req, .feat_addr, .set_params, .get_valid, .get_params,
    .reset_req, .reset_code, .prog_req, .prog_lun, .vol_sel_req,
    .vol_sel_addr, .term_matrix_set, .chain_enable_in, .chain_enable_out,
    .target_enabled, .timing_mode, .iface_type, .program_clear_select,
    .ext_reference_enable, .complementary_strobe_enable,
    .complementary_read_strobe_enable, .on_die_termination,
    .warm_out_cycles, .warm_in_cycles, .drive_level, .prog_supply_enable,
    .retry_disable, .volume_addr, .volume_selected, .page_clear_mask);

  nfps_host_model u_host (.sys_clk, .set_req, .get_req, .feat_addr,
    .set_params, .reset_req, .reset_code, .get_valid, .get_params);

  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Effective double-rate outputs packed for one compare
  function automatic logic [31:0] eff();
    return {ext_reference_enable, complementary_strobe_enable,
      complementary_read_strobe_enable, on_die_termination,
      warm_out_cycles, warm_in_cycles};
  endfunction : eff

  // Program pulse; the mask is a one-cycle strobe, so collect it
  task automatic prog(input logic [2:0] lun, input logic [3:0] exp);
    logic [3:0] seen;
    seen = 4'h0;
    @(negedge sys_clk);
    prog_req = 1'b1;
    prog_lun = lun;
    repeat (3) begin
      @(negedge sys_clk);
      prog_req = 1'b0;
      seen = seen | page_clear_mask;
    end
    chk(seen, exp);
  endtask : prog

  task automatic vsel(input logic [3:0] a, input logic exp);
    @(negedge sys_clk);
    vol_sel_req = 1'b1;
    vol_sel_addr = a;
    @(negedge sys_clk);
    vol_sel_req = 1'b0;
    @(negedge sys_clk);
    chk(volume_selected, exp);
  endtask : vsel

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_defaults;
    chk(drive_level, 2'h2);
    chk({timing_mode, iface_type, program_clear_select}, 7'h00);
    chk({prog_supply_enable, retry_disable}, 2'h0);
    u_host.fget(nfps_pkg::FA_DRIVE, rd);
    chk(rd, 32'h2);
    u_host.fget(nfps_pkg::FA_VOLUME, rd);
    chk(rd, 32'h0);
    $display("t_defaults done");
  endtask : t_defaults

  // Reserved and vendor addresses must not store and must answer with zero
  task automatic t_decode;
    logic [7:0] bad [6] = '{8'h00, 8'h03, 8'h11, 8'h60, 8'h80, 8'hff};
    foreach (bad[i]) begin
      u_host.fset(bad[i], 8'h01, 8'hff);
      u_host.fget(bad[i], rd);
      chk(rd, 32'h0);
    end
    chk({drive_level, timing_mode, prog_supply_enable}, 7'h40);
    $display("t_decode done");
  endtask : t_decode

  // Config acts only under the second double-rate interface
  task automatic t_ddr;
    logic [2:0] wexp [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h0};
    u_host.fset(nfps_pkg::FA_DDR_CFG, 8'h37, 8'h32);
    chk(eff(), 32'h0);
    u_host.fset(nfps_pkg::FA_TIMING, 8'he2, 8'h00);
    chk({timing_mode, iface_type, program_clear_select}, 7'h15);
    chk(eff(), {3'h7, 4'h3, 3'h4, 3'h2});
    for (int c = 0; c < 5; c++) begin
      u_host.fset(nfps_pkg::FA_DDR_CFG, 8'h10, {c[3:0], c[3:0]});
      chk({warm_out_cycles, warm_in_cycles}, {wexp[c], wexp[c]});
    end
    u_host.fset(nfps_pkg::FA_DDR_CFG, 8'h68, 8'h00);
    chk(on_die_termination, 4'h0);
    u_host.fget(nfps_pkg::FA_DDR_CFG, rd);
    chk(rd, 32'h60);
    u_host.fset(nfps_pkg::FA_DDR_CFG, 8'h57, 8'h33);
    term_matrix_set = 1'b1;
    @(negedge sys_clk);
    @(negedge sys_clk);
    chk(on_die_termination, 4'h0);
    term_matrix_set = 1'b0;
    @(negedge sys_clk);
    @(negedge sys_clk);
    chk(eff(), {3'h7, 4'h5, 3'h4, 3'h4});
    $display("t_ddr done");
  endtask : t_ddr

  // Chain pin is honoured only until an address is appointed
  task automatic t_volume;
    repeat (4) @(negedge sys_clk);
    chk({target_enabled, chain_enable_out}, 2'h0);
    chain_enable_in = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk(target_enabled, 1'b1);
    chain_enable_in = 1'b0;
    u_host.fset(nfps_pkg::FA_VOLUME, 8'hf3, 8'h00);
    chk({volume_addr, chain_enable_out, volume_selected}, 6'h0e);
    repeat (4) @(negedge sys_clk);
    chk(target_enabled, 1'b1);
    u_host.fset(nfps_pkg::FA_VOLUME, 8'h07, 8'h00);
    u_host.fget(nfps_pkg::FA_VOLUME, rd);
    chk(rd, 32'h3);
    vsel(4'h5, 1'b0);
    vsel(4'h3, 1'b1);
    $display("t_volume done");
  endtask : t_volume

  // Synchronous and LUN resets keep all; full reset drops double rate
  task automatic t_reset;
    logic [7:0] codes [3] = '{8'hfc, 8'hfa, 8'hff};
    u_host.fset(nfps_pkg::FA_DRIVE, 8'h01, 8'h00);
    u_host.fset(nfps_pkg::FA_SUPPLY, 8'h01, 8'h00);
    u_host.fset(nfps_pkg::FA_ECC, 8'h01, 8'h00);
    chk({drive_level, prog_supply_enable, retry_disable}, 4'h7);
    foreach (codes[i]) begin
      u_host.frst(codes[i]);
      chk({drive_level, prog_supply_enable, retry_disable}, 4'h7);
      chk({timing_mode, program_clear_select, volume_addr}, 9'h53);
      chk(iface_type, (i < 2) ? 2'b10 : 2'b00);
      u_host.fget(nfps_pkg::FA_DDR_CFG, rd);
      chk(rd, (i < 2) ? 32'h3357 : 32'h0);
    end
    chk(eff(), 32'h0);
    $display("t_reset done");
  endtask : t_reset

  // Clear select picks one LUN or all; first double rate also listed
  task automatic t_program;
    prog(3'h2, 4'h4);
    u_host.fset(nfps_pkg::FA_TIMING, 8'h12, 8'h00);
    chk({iface_type, program_clear_select}, 3'h2);
    prog(3'h1, 4'hf);
    $display("t_program done");
  endtask : t_program

  // Power cycle drops every setting, appointment included
  task automatic t_power;
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    chk({drive_level, prog_supply_enable, retry_disable}, 4'h8);
    chk({timing_mode, iface_type, chain_enable_out}, 7'h00);
    u_host.fset(nfps_pkg::FA_VOLUME, 8'h05, 8'h00);
    chk(volume_addr, 4'h5);
    $display("t_power done");
  endtask : t_power

  // ---------------------------------------------------------------
  // Main sequence and hang guard
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    t_defaults();
    t_decode();
    t_ddr();
    t_volume();
    t_reset();
    t_program();
    t_power();
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    report_and_stop();
  end
endmodule : nfps_feature_store_tb
`default_nettype wire
